// [cs_user_buf_pkg.sv]
// Constants, types and register map for the status/user data buffer.
// Assumes one 100 MHz clock shared with the receiver frame logic.
package cs_user_buf_pkg;

  // ----------------------------------------------------------------
  // Block geometry
  // ----------------------------------------------------------------
  localparam int unsigned FRAMES_PER_BLOCK = 192;   // Frames in one status block
  localparam int unsigned CS_WORDS         = 24;    // 16-bit words in status buffer
  localparam int unsigned USER_BYTES       = 48;    // Bytes of user data per block
  localparam int unsigned RESERVED_BYTES   = 5;     // Leading bytes kept for host
  localparam int unsigned HOLDOFF_FRAMES   = 24;    // Frames between two copies
  localparam int unsigned FIFO_DEPTH       = 16;    // Read data FIFO depth
  localparam int unsigned BYTE_W           = 8;     // Data byte width

  // ----------------------------------------------------------------
  // Control port map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] STAT_ADDR = 7'h1e;         // Buffer status, read only
  localparam logic [6:0] CTRL_ADDR = 7'h1f;         // Buffer control
  localparam logic [6:0] CS_BASE   = 7'h20;         // Status buffer, word 0
  localparam logic [6:0] USER_BASE = 7'h40;         // User buffer, word 0
  localparam logic [6:0] CS_SPAN   = 7'h18;         // Words in status region
  localparam logic [6:0] USER_SPAN = 7'h18;         // Words in user region

  // Control register fields
  localparam int unsigned CTRL_TWO_BYTE = 0;        // 1: two-byte status reads
  localparam int unsigned CTRL_CHAN_B   = 1;        // 1: one-byte reads use B
  localparam int unsigned CTRL_RESERVE  = 2;        // 1: keep first five bytes
  localparam int unsigned CTRL_INHIBIT  = 3;        // 1: hold block copies
  localparam int unsigned CTRL_IRQ_EN   = 4;        // 1: copy raises interrupt
  localparam logic [7:0]  CTRL_RESET    = 8'h00;    // Control value after reset

  // Status bits inside channel A bytes (MSB first received)
  localparam int unsigned COPY_BYTE = 0;            // Byte holding copy flag
  localparam int unsigned COPY_BIT  = 5;            // Stream bit 2
  localparam int unsigned GEN_BYTE  = 1;            // Byte holding generation flag
  localparam int unsigned GEN_BIT   = 0;            // Stream bit 15

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,                              // No read running
    RD_FIRST = 3'b010,                              // Pushing first byte
    RD_SECND = 3'b100                               // Pushing second byte
  } rd_state_e;

  typedef struct packed {
    logic       tick;                               // One frame received
    logic       block_start;                        // Frame 0 of a block
    logic       cs_a;                               // Status bit, sub-frame A
    logic       cs_b;                               // Status bit, sub-frame B
    logic       u_a;                                // User bit, sub-frame A
    logic       u_b;                                // User bit, sub-frame B
  } rx_frame_s;

  typedef struct packed {
    logic       addr_load;                          // Load address pointer
    logic [6:0] addr;                               // Address to load
    logic       wr;                                 // Write byte, then increment
    logic [7:0] wdata;                              // Byte to write
    logic       rd;                                 // Read at pointer, increment
  } cp_req_s;

endpackage

// [cs_user_buf.sv]
// Received channel status and user data double buffer, with read FIFO.
// Assumes frame strobes come from receiver logic on the same clock.
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Read data FIFO
// ------------------------------------------------------------------
module cs_user_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];                    // Storage words
  logic [AW:0]      wr_ptr;                         // Write pointer, wrap bit on top
  logic [AW:0]      rd_ptr;                         // Read pointer, wrap bit on top
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign o_in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_out_data  = mem[rd_ptr[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer update
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer and storage registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule // cs_user_fifo

// ------------------------------------------------------------------
// Buffer top
// ------------------------------------------------------------------
module cs_user_buf (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset,
  // Receiver frame strobe and bits
  input  wire cs_user_buf_pkg::rx_frame_s  i_rx,
  // Control port requests
  input  wire cs_user_buf_pkg::cp_req_s    i_cp,
  output logic                             o_cp_busy,
  // Control port read bytes
  output logic                             o_rd_valid,
  output logic [7:0]                       o_rd_data,
  input  wire logic                        i_rd_ready,
  // Events and pins
  output logic                             o_xfer_irq,
  output logic                             o_user_serial,
  output logic                             o_cs_serial,
  output logic                             o_copy_permit,
  output logic                             first_generation_flag_out
);
  import cs_user_buf_pkg::*;

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic in_cs(input logic [6:0] a);
    in_cs = (a >= CS_BASE) && (a < CS_BASE + CS_SPAN);
  endfunction

  function automatic logic in_user(input logic [6:0] a);
    in_user = (a >= USER_BASE) && (a < USER_BASE + USER_SPAN);
  endfunction

  function automatic logic [4:0] word_of(input logic [6:0] a, input logic [6:0] base);
    logic [6:0] d;
    d       = a - base;
    word_of = d[4:0];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] d_cs_a [CS_WORDS];                    // Capture, channel A status
  logic [7:0] d_cs_b [CS_WORDS];                    // Capture, channel B status
  logic [7:0] d_user [USER_BYTES];                  // Capture, user bytes
  logic [7:0] e_cs_a [CS_WORDS];                    // Host view, channel A status
  logic [7:0] e_cs_b [CS_WORDS];                    // Host view, channel B status
  logic [7:0] e_user [USER_BYTES];                  // Host view, user bytes
  logic [7:0] next_d_cs_a [CS_WORDS];
  logic [7:0] next_d_cs_b [CS_WORDS];
  logic [7:0] next_d_user [USER_BYTES];
  logic [7:0] next_e_cs_a [CS_WORDS];
  logic [7:0] next_e_cs_b [CS_WORDS];
  logic [7:0] next_e_user [USER_BYTES];
  logic [7:0] frame_cnt;                            // Frame index in block
  logic [7:0] next_frame_cnt;
  logic       pending;                              // Complete block waits for copy
  logic       next_pending;
  logic [4:0] holdoff;                              // Frames left before next copy
  logic [4:0] next_holdoff;
  logic [7:0] ctrl;                                 // Buffer control register
  logic [7:0] next_ctrl;
  logic [6:0] addr;                                 // Auto-increment pointer
  logic [6:0] next_addr;
  rd_state_e  rd_state;
  rd_state_e  next_rd_state;
  logic       irq;
  logic       next_irq;
  logic       user_ser;
  logic       next_user_ser;
  logic       cs_ser;
  logic       next_cs_ser;

  // Working values
  logic [7:0] idx;                                  // Frame slot being written
  logic       block_done;                           // Last frame of block captured
  logic       copy_fire;                            // Block copy this cycle
  logic       host_wr;                              // Accepted host write
  logic [7:0] push_data;
  logic       push_valid;
  logic       push_ready;
  logic [4:0] w;

  localparam logic [7:0] LAST_FRAME = 8'(FRAMES_PER_BLOCK - 1);
  localparam logic [4:0] HOLDOFF_LD = 5'(HOLDOFF_FRAMES);

  assign idx        = i_rx.block_start ? 8'h00 : frame_cnt;
  assign block_done = i_rx.tick && (idx == LAST_FRAME);
  // A copy reads the registered capture block, so a tick in the same cycle
  // only writes the next block and cannot mix into this one
  assign copy_fire  = pending && !ctrl[CTRL_INHIBIT]
                      && (holdoff == 5'h00);
  // Pointer load has priority, so a load never also writes
  assign host_wr    = i_cp.wr && !i_cp.addr_load && (rd_state == RD_IDLE);
  assign o_cp_busy  = (rd_state != RD_IDLE);

  // ----------------------------------------------------------------
  // Capture and host-view buffers
  // ----------------------------------------------------------------
  // Capture writes one bit per channel per frame, MSB first; the copy moves
  // every unreserved byte in a single cycle so the host never sees two blocks mixed.
  always_comb begin
    next_d_cs_a = d_cs_a;
    next_d_cs_b = d_cs_b;
    next_d_user = d_user;
    next_e_cs_a = e_cs_a;
    next_e_cs_b = e_cs_b;
    next_e_user = e_user;
    if (i_rx.tick) begin
      next_d_cs_a[idx[7:3]][3'h7 - idx[2:0]] = i_rx.cs_a;
      next_d_cs_b[idx[7:3]][3'h7 - idx[2:0]] = i_rx.cs_b;
      // User bits arrive A then B, so two per frame in stream order
      next_d_user[idx[7:2]][3'h7 - {idx[1:0], 1'b0}] = i_rx.u_a;
      next_d_user[idx[7:2]][3'h6 - {idx[1:0], 1'b0}] = i_rx.u_b;
    end
    if (copy_fire) begin
      for (int i = 0; i < CS_WORDS; i++) begin
        // Reserved leading bytes are bytes 2i (A) and 2i+1 (B)
        if (!(ctrl[CTRL_RESERVE] && (2 * i < RESERVED_BYTES))) begin
          next_e_cs_a[i] = d_cs_a[i];
        end
        if (!(ctrl[CTRL_RESERVE] && (2 * i + 1 < RESERVED_BYTES))) begin
          next_e_cs_b[i] = d_cs_b[i];
        end
      end
      next_e_user = d_user;
    end
    // Host writes land after the copy, so they win the same cycle
    if (host_wr && in_cs(addr)) begin
      if (ctrl[CTRL_CHAN_B]) begin
        next_e_cs_b[word_of(addr, CS_BASE)] = i_cp.wdata;
      end else begin
        next_e_cs_a[word_of(addr, CS_BASE)] = i_cp.wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < CS_WORDS; i++) begin
        d_cs_a[i] <= 8'h00;
        d_cs_b[i] <= 8'h00;
        e_cs_a[i] <= 8'h00;
        e_cs_b[i] <= 8'h00;
      end
      for (int i = 0; i < USER_BYTES; i++) begin
        d_user[i] <= 8'h00;
        e_user[i] <= 8'h00;
      end
    end else begin
      d_cs_a <= next_d_cs_a;
      d_cs_b <= next_d_cs_b;
      d_user <= next_d_user;
      e_cs_a <= next_e_cs_a;
      e_cs_b <= next_e_cs_b;
      e_user <= next_e_user;
    end
  end

  // ----------------------------------------------------------------
  // Block sequencing, spacing and serial pins
  // ----------------------------------------------------------------
  // A block still waiting when the next frame lands is dropped rather than
  // copied half new; software must keep the inhibit short.
  always_comb begin
    next_frame_cnt = frame_cnt;
    if (i_rx.tick) begin
      next_frame_cnt = block_done ? 8'h00 : idx + 8'h01;
    end
    // A new block end wins over the copy that clears the flag
    next_pending = block_done || (pending && !copy_fire && !i_rx.tick);
    next_holdoff = holdoff;
    if (copy_fire) begin
      next_holdoff = HOLDOFF_LD;
    end else if (i_rx.tick && (holdoff != 5'h00)) begin
      next_holdoff = holdoff - 5'h01;
    end
    next_irq      = copy_fire && ctrl[CTRL_IRQ_EN];
    next_user_ser = i_rx.tick ? i_rx.u_a : user_ser;
    next_cs_ser   = i_rx.tick ? i_rx.cs_a : cs_ser;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      frame_cnt <= 8'h00;
      pending   <= 1'b0;
      holdoff   <= 5'h00;
      irq       <= 1'b0;
      user_ser  <= 1'b0;
      cs_ser    <= 1'b0;
    end else begin
      frame_cnt <= next_frame_cnt;
      pending   <= next_pending;
      holdoff   <= next_holdoff;
      irq       <= next_irq;
      user_ser  <= next_user_ser;
      cs_ser    <= next_cs_ser;
    end
  end

  assign o_xfer_irq    = irq;
  assign o_user_serial = user_ser;
  assign o_cs_serial   = cs_ser;
  // Pin decisions use the host-view channel A block
  assign o_copy_permit = e_cs_a[COPY_BYTE][COPY_BIT];
  assign first_generation_flag_out = e_cs_a[GEN_BYTE][GEN_BIT];

  // ----------------------------------------------------------------
  // Control port: pointer, control register and read engine
  // ----------------------------------------------------------------
  // Byte to push: first or second half of the current access
  always_comb begin
    w         = word_of(addr, in_user(addr) ? USER_BASE : CS_BASE);
    push_data = 8'h00;
    if (in_cs(addr)) begin
      if (rd_state == RD_SECND) begin
        push_data = e_cs_b[w];
      end else if (!ctrl[CTRL_TWO_BYTE] && ctrl[CTRL_CHAN_B]) begin
        push_data = e_cs_b[w];
      end else begin
        push_data = e_cs_a[w];
      end
    end else if (in_user(addr)) begin
      push_data = e_user[{w, rd_state == RD_SECND}];
    end else if (addr == CTRL_ADDR) begin
      push_data = ctrl;
    end else if (addr == STAT_ADDR) begin
      push_data = {5'h00, holdoff != 5'h00, ctrl[CTRL_INHIBIT], pending};
    end
    push_valid = (rd_state != RD_IDLE);
  end

  // Requests are taken only while idle; busy tells the port to wait
  always_comb begin
    next_rd_state = rd_state;
    next_addr     = addr;
    next_ctrl     = ctrl;
    unique case (rd_state)
      RD_IDLE: begin
        if (i_cp.addr_load) begin
          next_addr = i_cp.addr;
        end else if (host_wr) begin
          if (addr == CTRL_ADDR) begin
            next_ctrl = i_cp.wdata;
          end
          next_addr = addr + 7'h01;
        end else if (i_cp.rd) begin
          next_rd_state = RD_FIRST;
        end
      end
      RD_FIRST: begin
        if (push_ready) begin
          if (in_user(addr) || (in_cs(addr) && ctrl[CTRL_TWO_BYTE])) begin
            next_rd_state = RD_SECND;
          end else begin
            next_rd_state = RD_IDLE;
            next_addr     = addr + 7'h01;
          end
        end
      end
      RD_SECND: begin
        if (push_ready) begin
          next_rd_state = RD_IDLE;
          next_addr     = addr + 7'h01;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rd_state <= RD_IDLE;
      addr     <= 7'h00;
      ctrl     <= CTRL_RESET;
    end else begin
      rd_state <= next_rd_state;
      addr     <= next_addr;
      ctrl     <= next_ctrl;
    end
  end

  // Read bytes queue here; a slow port stalls the engine, not the data
  cs_user_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .i_in_data   (push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rd_valid),
    .o_out_data  (o_rd_data),
    .i_out_ready (i_rd_ready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_irq_on_copy;
    copy_fire && ctrl[CTRL_IRQ_EN] |=> o_xfer_irq;
  endproperty
  a_irq_on_copy: assert property (p_irq_on_copy)
    else $error("copy did not raise interrupt");

  property p_irq_cause;
    o_xfer_irq |-> $past(copy_fire) && $past(ctrl[CTRL_IRQ_EN]);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without copy");

  property p_inhibit;
    ctrl[CTRL_INHIBIT] |-> !copy_fire;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("copy while inhibited");

  property p_spacing;
    copy_fire |=> !copy_fire [*8];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("copies too close");

  property p_reserve;
    copy_fire && ctrl[CTRL_RESERVE] && !host_wr |=> e_cs_a[2] == $past(e_cs_a[2]);
  endproperty
  a_reserve: assert property (p_reserve)
    else $error("reserved byte overwritten");

  property p_whole_copy;
    copy_fire && !host_wr |=> (e_cs_b[23] == $past(d_cs_b[23]))
                              && (e_user[47] == $past(d_user[47]));
  endproperty
  a_whole_copy: assert property (p_whole_copy)
    else $error("block copy incomplete");

  property p_two_byte;
    rd_state == RD_FIRST && push_ready && in_user(addr) |=> rd_state == RD_SECND;
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("user read not two bytes");

  property p_a_then_b;
    rd_state == RD_SECND && in_cs(addr) |-> push_data == e_cs_b[w] && $past(rd_state) != RD_IDLE;
  endproperty
  a_a_then_b: assert property (p_a_then_b)
    else $error("second byte not channel B");

  property p_incr;
    rd_state == RD_SECND && push_ready |=> addr == $past(addr) + 7'h01 && rd_state == RD_IDLE;
  endproperty
  a_incr: assert property (p_incr)
    else $error("pointer did not advance");

  property p_serial;
    !i_rx.tick |=> o_user_serial == $past(o_user_serial);
  endproperty
  a_serial: assert property (p_serial)
    else $error("user pin moved without frame");
endmodule // cs_user_buf

// [cs_user_host.sv]
// Host model on the control port: one request at a time, random drain stalls.
// Assumes a request is taken on the edge after it is driven, with busy low.
`timescale 1ns/10ps
module cs_user_host (
  // Clock
  input  wire logic                i_ref_clk,
  // Buffer side
  input  wire logic                i_cp_busy,
  input  wire logic                i_rd_valid,
  input  wire logic [7:0]          i_rd_data,
  output cs_user_buf_pkg::cp_req_s o_cp,
  output logic                     o_rd_ready
);
  import cs_user_buf_pkg::*;
  logic [7:0] got[$]; // Bytes drained so far
  initial o_cp = '0;
  initial o_rd_ready = 1'b0;
  // Drain with stalls so the FIFO backs up now and then
  always @(posedge i_ref_clk) begin
    if (i_rd_valid && o_rd_ready) got.push_back(i_rd_data); // Every drained byte kept for the bench
    o_rd_ready <= 1'($urandom % 4 != 0);
  end
  // One pulse, then wait until the read engine is idle
  task automatic req(input cp_req_s r);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_cp <= r;
    @(posedge i_ref_clk);
    o_cp <= '0;
    do @(posedge i_ref_clk); while (i_cp_busy && n++ < 300);
  endtask
  // Pointer load then one byte write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req('{addr_load:1'b1, addr:a, default:'0});
    req('{wr:1'b1, wdata:d, default:'0});
  endtask
endmodule // cs_user_host

// [cs_user_buf_tb.sv]
// Self-checking bench: random blocks with inhibit, reserve and read-mode cases.
// Assumes the host model in cs_user_host.sv drives the control port.
`timescale 1ns/10ps
module cs_user_buf_tb;
  import cs_user_buf_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_reset = 1'b1;
  rx_frame_s  rx = '0;
  cp_req_s    cp;
  logic       busy, rvalid, rready, irq, user_ser, cs_ser, permit, gen;
  logic [7:0] rdata;
  logic [7:0] ca[24], cb[24], cu[48]; // Captured block
  logic [7:0] va[24], vb[24], vu[48]; // Expected host view
  logic [7:0] rv[5];                  // Reserved bytes written
  int         failures = 0;
  int         tests_run = 0;
  int         irqs = 0;               // Transfer pulses seen
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (irq === 1'b1) irqs++;
  cs_user_buf i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_rx(rx), .i_cp(cp),
    .o_cp_busy(busy), .o_rd_valid(rvalid), .o_rd_data(rdata), .i_rd_ready(rready),
    .o_xfer_irq(irq), .o_user_serial(user_ser), .o_cs_serial(cs_ser),
    .o_copy_permit(permit), .first_generation_flag_out(gen));
  cs_user_host i_host (.i_ref_clk(i_ref_clk), .i_cp_busy(busy), .i_rd_valid(rvalid),
    .i_rd_data(rdata), .o_cp(cp), .o_rd_ready(rready));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One random block, three cycles a frame; serial pins carry channel A
  task automatic send_block;
    logic [3:0] r;
    for (int k = 0; k < 192; k++) begin
      r = 4'($urandom);
      ca[k/8][7-k%8] = r[0]; // Earliest bit lands in the MSB
      cb[k/8][7-k%8] = r[1];
      cu[k/4][7-2*(k%4)] = r[2];
      cu[k/4][6-2*(k%4)] = r[3];
      @(posedge i_ref_clk);
      rx <= '{tick:1'b1, block_start:(k == 0), cs_a:r[0], cs_b:r[1], u_a:r[2], u_b:r[3]};
      @(posedge i_ref_clk);
      rx <= '0;
      @(posedge i_ref_clk);
      chk({7'h0, user_ser}, {7'h0, r[2]});
      chk({7'h0, cs_ser}, {7'h0, r[0]});
    end
    repeat (6) @(posedge i_ref_clk);
  endtask
  // Load pointer, issue n reads, wait for nb bytes under a bound
  task automatic rd_blk(input logic [6:0] a, input int n, input int nb);
    int t;
    t = 0;
    i_host.got.delete();
    i_host.req('{addr_load:1'b1, addr:a, default:'0});
    repeat (n) i_host.req('{rd:1'b1, default:'0});
    while (i_host.got.size() < nb && t++ < 500) @(posedge i_ref_clk);
  endtask
  task automatic chk_two(input logic [6:0] base);
    rd_blk(base, 24, 48);
    for (int w = 0; w < 24; w++) begin
      chk(i_host.got[2*w], base == USER_BASE ? vu[2*w] : va[w]);
      chk(i_host.got[2*w+1], base == USER_BASE ? vu[2*w+1] : vb[w]);
    end
  endtask
  task automatic chk_one(input logic chan_b);
    rd_blk(CS_BASE, 24, 24);
    for (int w = 0; w < 24; w++)
      chk(i_host.got[w], chan_b ? vb[w] : va[w]);
  endtask
  initial begin
    void'($urandom(32'h267cd62c));
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd_blk(CTRL_ADDR, 1, 1);
    chk(i_host.got[0], CTRL_RESET);
    rd_blk(STAT_ADDR, 1, 1);
    chk(i_host.got[0], 8'h00);
    // Two-byte mode, pulses enabled
    i_host.wr(CTRL_ADDR, 8'h11);
    send_block;
    chk(8'(irqs), 8'h01);
    va = ca; vb = cb; vu = cu;
    chk({7'h0, permit}, {7'h0, va[COPY_BYTE][COPY_BIT]});
    chk({7'h0, gen}, {7'h0, va[GEN_BYTE][GEN_BIT]});
    chk_two(CS_BASE);
    chk_two(USER_BASE);
    i_host.wr(CTRL_ADDR, 8'h02);
    chk_one(1'b1);
    // Inhibit keeps the old block visible until released
    i_host.wr(CTRL_ADDR, 8'h18);
    send_block;
    chk(8'(irqs), 8'h01);
    chk_one(1'b0);
    i_host.wr(CTRL_ADDR, 8'h11);
    repeat (6) @(posedge i_ref_clk);
    chk(8'(irqs), 8'h02);
    va = ca; vb = cb; vu = cu;
    chk_two(CS_BASE);
    // Reserved bytes A0,B0,A1,B1,A2 survive a copy
    for (int i = 0; i < 5; i++) begin
      rv[i] = 8'($urandom);
      i_host.wr(CTRL_ADDR, i % 2 ? 8'h07 : 8'h05);
      i_host.wr(CS_BASE + 7'(i / 2), rv[i]);
    end
    i_host.wr(CTRL_ADDR, 8'h05);
    send_block;
    chk(8'(irqs), 8'h02);
    va = ca; vb = cb; vu = cu;
    for (int i = 0; i < 5; i++)
      if (i % 2) vb[i/2] = rv[i];
      else va[i/2] = rv[i];
    chk_two(CS_BASE);
    // Mid-run reset wipes control, channel A host view and user serial pin
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd_blk(CTRL_ADDR, 1, 1);
    chk(i_host.got[0], CTRL_RESET);
    chk({7'h0, user_ser}, 8'h00);
    va = '{default: 8'h00};
    chk_one(1'b0);
    tally_and_finish;
  end
  // Watchdog, about 50000 cycles
  initial begin
    #500000;
    failures++;
    tally_and_finish;
  end
endmodule // cs_user_buf_tb
